// ===== hw/dswk_defines.svh
`ifndef DSWK_DEFINES_SVH
`define DSWK_DEFINES_SVH

// Register indices; byte address is four times the index
`define DSWK_IDX_WDT_CTL 14'h0f48
`define DSWK_IDX_WAKE_LOW 14'h0f4a
`define DSWK_IDX_WAKE_HIGH 14'h0f4b
`define DSWK_IDX_DS_CTL_LOW 14'h0f4c
`define DSWK_IDX_DS_CTL_HIGH 14'h0f4d
`define DSWK_IDX_PERSIST1 14'h0f4f

// deep_sleep_wake_low fields
`define DSWK_BIT_FAULT 7
`define DSWK_BIT_ULP 5
`define DSWK_BIT_WDT 4
`define DSWK_BIT_RTC 3
`define DSWK_BIT_EXTERNAL_RESET_PIN 2
`define DSWK_BIT_POR 0
// deep_sleep_wake_high fields
`define DSWK_BIT_INT0 0
// watchdog_control fields
`define DSWK_BIT_LEVEL 5
`define DSWK_BIT_MOD_EN 1
`define DSWK_BIT_SINK 0
// deep sleep control fields
`define DSWK_BIT_DS_ULP_EN 1
`define DSWK_BIT_ULP_WDIS 2

// Reset values
`define DSWK_RST_WAKE_LOW 8'h01
`define DSWK_RST_WAKE_HIGH 8'h00
`define DSWK_RST_PERSIST 8'h00
`define DSWK_RST_CTL 8'h00

// Bus answers
`define DSWK_RESP_OKAY 2'h0
`define DSWK_RESP_SLVERR 2'h2

`endif

// ===== hw/dswk_pkg.sv
`include "dswk_defines.svh"

package dswk_pkg;

  typedef enum logic [2:0] {
    DSWK_SEL_NONE,
    DSWK_SEL_WDT_CTL,
    DSWK_SEL_WAKE_LOW,
    DSWK_SEL_WAKE_HIGH,
    DSWK_SEL_DS_LOW,
    DSWK_SEL_DS_HIGH,
    DSWK_SEL_PERSIST
  } dswk_sel_t;

  // Wake causes seen while asleep
  typedef struct packed {
    logic fault;
    logic watchdog;
    logic alarm;
    logic reset_pin_n;
    logic change_int;
  } dswk_events_t;

  // Supply monitor results
  typedef struct packed {
    logic por_event;
    logic por_active;
    logic core_brownout;
    logic sleep_brownout;
    logic supply_cycled;
  } dswk_supply_t;

  typedef struct packed {
    logic in_sleep;
    logic in_deep_sleep;
  } dswk_power_t;

  function automatic dswk_sel_t dswk_decode(input logic [15:0] addr);
    dswk_sel_t sel;
    sel = DSWK_SEL_NONE;
    case (addr[15:2])
      `DSWK_IDX_WDT_CTL: sel = DSWK_SEL_WDT_CTL;
      `DSWK_IDX_WAKE_LOW: sel = DSWK_SEL_WAKE_LOW;
      `DSWK_IDX_WAKE_HIGH: sel = DSWK_SEL_WAKE_HIGH;
      `DSWK_IDX_DS_CTL_LOW: sel = DSWK_SEL_DS_LOW;
      `DSWK_IDX_DS_CTL_HIGH: sel = DSWK_SEL_DS_HIGH;
      `DSWK_IDX_PERSIST1: sel = DSWK_SEL_PERSIST;
      default: sel = DSWK_SEL_NONE;
    endcase
    return sel;
  endfunction : dswk_decode

endpackage : dswk_pkg

// ===== hw/dswk_axil_slave.sv
`timescale 1ns/100ps
`include "dswk_defines.svh"

module dswk_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address and data
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [15:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic w_have;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [15:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dswk_slv_state_t;

  dswk_slv_state_t s_r;
  dswk_slv_state_t s_nxt;
  logic fire;

  always_comb begin
    s_nxt = s_r;
    fire = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
    if (awvalid & s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid & s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    // Both halves held: commit and answer
    if (fire) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_hit ? `DSWK_RESP_OKAY : `DSWK_RESP_SLVERR;
    end
    if (s_r.bvalid & bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (arvalid & s_r.arready) begin
      s_nxt.ar_have = 1'b1;
      s_nxt.araddr = araddr;
    end
    if (s_r.ar_have & ~s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = rd_hit ? `DSWK_RESP_OKAY : `DSWK_RESP_SLVERR;
    end
    if (s_r.rvalid & rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.ar_have = 1'b0;
    end
    s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_have & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.ar_have;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign arready = s_r.arready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign wr_en = fire;
  assign wr_addr = s_r.awaddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;
  assign rd_addr = s_r.araddr;

endmodule : dswk_axil_slave

// ===== hw/dswk_ulp_wake.sv
`timescale 1ns/100ps

module dswk_ulp_wake (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic module_en,
  input wire logic sink_en,
  input wire logic ds_module_en,
  input wire logic ds_wake_dis,
  input wire dswk_pkg::dswk_power_t power,
  // Capacitor pin compare, high while below input-low threshold
  input wire logic pin_low,
  // Results
  output logic sink_on,
  output logic wake_out,
  output logic sleep_wake,
  output logic deep_wake
);

  typedef struct packed {
    logic sink_on;
    logic wake_out;
    logic pin_low_d;
    logic sleep_wake;
    logic deep_wake;
  } dswk_ulp_state_t;

  dswk_ulp_state_t s_r;
  dswk_ulp_state_t s_nxt;
  logic armed;
  logic fall;

  always_comb begin
    s_nxt = s_r;
    // Deep sleep arms from its own enable, ordinary sleep from the module enable
    armed = power.in_deep_sleep ? ds_module_en : module_en;
    fall = armed & pin_low & ~s_r.pin_low_d;
    s_nxt.pin_low_d = pin_low;
    s_nxt.sink_on = module_en & sink_en; // [R16]
    s_nxt.wake_out = module_en & pin_low; // [R17]
    s_nxt.sleep_wake = fall & power.in_sleep & ~power.in_deep_sleep; // [R12]
    s_nxt.deep_wake = fall & power.in_deep_sleep & ~ds_wake_dis; // [R18]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Start as if already low: a pin low at reset gives no false wake
      s_r <= '{pin_low_d: 1'b1, default: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sink_on = s_r.sink_on;
  assign wake_out = s_r.wake_out;
  assign sleep_wake = s_r.sleep_wake;
  assign deep_wake = s_r.deep_wake;

endmodule : dswk_ulp_wake

// ===== hw/dswk_top.sv
// Contract
// R1: The second persistent byte keeps all eight bits unchanged throughout deep sleep.
// R2: The byte clears only on core brown-out, deep-sleep brown-out or supply cycling; the code also clears it on a power-on event.
// R3: Change interrupt during deep sleep sets high wake byte bit 0.
// R4: Unimplemented wake byte bits read zero: high 7..1, low 6 and 1.
// R5: Self-monitor fault during deep sleep sets low wake byte bit 7.
// R6: Low-power wake event during deep sleep sets low wake byte bit 5.
// R7: Deep-sleep watchdog timeout during deep sleep sets low wake byte bit 4.
// R8: Calendar alarm during deep sleep sets low wake byte bit 3.
// R9: External reset pin low during deep sleep sets low wake byte bit 2.
// R10: Power-on event with the power-on circuit active sets low wake byte bit 0.
// R11: The power-on flag may also be set outside deep sleep.
// R12: Wake pin falling below input-low raises a wake interrupt from sleep.
// R13: Low-power wake from ordinary sleep sets watchdog control bit 5.
// R14: Low-power wake from deep sleep sets low wake byte bit 5.
// R15: Software routes the wake output and charges the capacitor before sleeping.
// R16: Software enables module and sink bits to start the capacitor discharge.
// R17: In ordinary sleep only the low-power wake output drives the pin state.
// R18: Low-power wake ends deep sleep only when enabled and not disabled.
// R19: A deep-sleep fault leaves deep sleep through power-on sequence, no setup.
// R20: Wake flags survive the post-wake reset; software writes update them.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dswk_defines.svh"

module dswk_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power state and supply monitor
  input wire dswk_pkg::dswk_power_t power,
  input wire dswk_pkg::dswk_supply_t supply,
  // Wake causes
  input wire dswk_pkg::dswk_events_t events,
  input wire logic wake_capacitor_pin_low,
  // Wake results
  output logic discharge_sink_on,
  output logic low_power_wake_output,
  output logic wake_irq,
  output logic deep_sleep_exit_req
);

  typedef struct packed {
    logic [7:0] persist;
    logic sleep_fault_flag;
    logic low_power_wake_flag;
    logic sleep_watchdog_flag;
    logic calendar_alarm_flag;
    logic reset_pin_flag;
    logic power_on_flag;
    logic change_interrupt_wake_flag;
    logic wake_module_enable;
    logic discharge_sink_enable;
    logic wake_level_flag;
    logic sleep_wake_module_enable;
    logic sleep_wake_source_disable;
    logic wake_irq;
    logic exit_req;
  } dswk_top_state_t;

  dswk_top_state_t s_r;
  dswk_top_state_t s_nxt;

  logic wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  dswk_pkg::dswk_sel_t wr_sel;
  dswk_pkg::dswk_sel_t rd_sel;
  logic ulp_sleep_wake;
  logic ulp_deep_wake;
  logic deep;
  logic persist_loss;
  logic exit_cause;

  dswk_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  dswk_ulp_wake u_ulp (
    .aclk(aclk),
    .aresetn(aresetn),
    .module_en(s_r.wake_module_enable),
    .sink_en(s_r.discharge_sink_enable),
    .ds_module_en(s_r.sleep_wake_module_enable),
    .ds_wake_dis(s_r.sleep_wake_source_disable),
    .power(power),
    .pin_low(wake_capacitor_pin_low),
    .sink_on(discharge_sink_on),
    .wake_out(low_power_wake_output),
    .sleep_wake(ulp_sleep_wake),
    .deep_wake(ulp_deep_wake)
  );

  // Address decode shared by both directions
  always_comb begin
    wr_sel = dswk_pkg::dswk_decode(wr_addr);
    rd_sel = dswk_pkg::dswk_decode(rd_addr);
    wr_hit = (wr_sel != dswk_pkg::DSWK_SEL_NONE);
    rd_hit = (rd_sel != dswk_pkg::DSWK_SEL_NONE);
  end

  // Read mux; unlisted bits stay zero
  always_comb begin
    rd_data = 32'h0;
    case (rd_sel)
      dswk_pkg::DSWK_SEL_WDT_CTL: begin
        rd_data[`DSWK_BIT_LEVEL] = s_r.wake_level_flag;
        rd_data[`DSWK_BIT_MOD_EN] = s_r.wake_module_enable;
        rd_data[`DSWK_BIT_SINK] = s_r.discharge_sink_enable;
      end
      dswk_pkg::DSWK_SEL_WAKE_LOW: begin
        rd_data[`DSWK_BIT_FAULT] = s_r.sleep_fault_flag; // [R4]
        rd_data[`DSWK_BIT_ULP] = s_r.low_power_wake_flag;
        rd_data[`DSWK_BIT_WDT] = s_r.sleep_watchdog_flag;
        rd_data[`DSWK_BIT_RTC] = s_r.calendar_alarm_flag;
        rd_data[`DSWK_BIT_EXTERNAL_RESET_PIN] = s_r.reset_pin_flag;
        rd_data[`DSWK_BIT_POR] = s_r.power_on_flag;
      end
      dswk_pkg::DSWK_SEL_WAKE_HIGH: begin
        rd_data[`DSWK_BIT_INT0] = s_r.change_interrupt_wake_flag; // [R4]
      end
      dswk_pkg::DSWK_SEL_DS_LOW: begin
        rd_data[`DSWK_BIT_ULP_WDIS] = s_r.sleep_wake_source_disable;
      end
      dswk_pkg::DSWK_SEL_DS_HIGH: begin
        rd_data[`DSWK_BIT_DS_ULP_EN] = s_r.sleep_wake_module_enable;
      end
      dswk_pkg::DSWK_SEL_PERSIST: begin
        rd_data[7:0] = s_r.persist;
      end
      default: begin
        rd_data = 32'h0;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    deep = power.in_deep_sleep;

    // Software writes first, so hardware sets below win a same-cycle clear
    if (wr_en && wr_hit && wr_strb[0]) begin
      case (wr_sel)
        dswk_pkg::DSWK_SEL_WDT_CTL: begin
          s_nxt.wake_level_flag = wr_data[`DSWK_BIT_LEVEL];
          s_nxt.wake_module_enable = wr_data[`DSWK_BIT_MOD_EN];
          s_nxt.discharge_sink_enable = wr_data[`DSWK_BIT_SINK];
        end
        dswk_pkg::DSWK_SEL_WAKE_LOW: begin
          s_nxt.sleep_fault_flag = wr_data[`DSWK_BIT_FAULT]; // [R20]
          s_nxt.low_power_wake_flag = wr_data[`DSWK_BIT_ULP];
          s_nxt.sleep_watchdog_flag = wr_data[`DSWK_BIT_WDT];
          s_nxt.calendar_alarm_flag = wr_data[`DSWK_BIT_RTC];
          s_nxt.reset_pin_flag = wr_data[`DSWK_BIT_EXTERNAL_RESET_PIN];
          s_nxt.power_on_flag = wr_data[`DSWK_BIT_POR];
        end
        dswk_pkg::DSWK_SEL_WAKE_HIGH: begin
          s_nxt.change_interrupt_wake_flag = wr_data[`DSWK_BIT_INT0]; // [R20]
        end
        dswk_pkg::DSWK_SEL_DS_LOW: begin
          s_nxt.sleep_wake_source_disable = wr_data[`DSWK_BIT_ULP_WDIS];
        end
        dswk_pkg::DSWK_SEL_DS_HIGH: begin
          s_nxt.sleep_wake_module_enable = wr_data[`DSWK_BIT_DS_ULP_EN];
        end
        dswk_pkg::DSWK_SEL_PERSIST: begin
          // Bus is idle in deep sleep; a stray write still cannot disturb the byte
          if (!deep) begin
            s_nxt.persist = wr_data[7:0]; // [R1]
          end
        end
        default: begin
          s_nxt.persist = s_r.persist;
        end
      endcase
    end

    // Sticky wake causes, recorded while in deep sleep; the level flag from an ordinary-sleep wake
    if (deep && events.change_int) begin
      s_nxt.change_interrupt_wake_flag = 1'b1; // [R3]
    end
    if (deep && events.fault) begin
      s_nxt.sleep_fault_flag = 1'b1; // [R5]
    end
    if (ulp_deep_wake) begin
      s_nxt.low_power_wake_flag = 1'b1; // [R6] [R14]
    end
    if (deep && events.watchdog) begin
      s_nxt.sleep_watchdog_flag = 1'b1; // [R7]
    end
    if (deep && events.alarm) begin
      s_nxt.calendar_alarm_flag = 1'b1; // [R8]
    end
    if (deep && !events.reset_pin_n) begin
      s_nxt.reset_pin_flag = 1'b1; // [R9]
    end
    if (ulp_sleep_wake) begin
      s_nxt.wake_level_flag = 1'b1; // [R13]
    end

    // Power-up: wake flags to defaults, power-on flag from the detector in any state
    if (supply.por_event) begin
      s_nxt.sleep_fault_flag = 1'b0;
      s_nxt.low_power_wake_flag = 1'b0;
      s_nxt.sleep_watchdog_flag = 1'b0;
      s_nxt.calendar_alarm_flag = 1'b0;
      s_nxt.reset_pin_flag = 1'b0;
      s_nxt.change_interrupt_wake_flag = 1'b0;
      s_nxt.sleep_wake_module_enable = 1'b0;
      s_nxt.sleep_wake_source_disable = 1'b0;
      s_nxt.power_on_flag = supply.por_active; // [R10] [R11]
    end

    // Only these supply losses may corrupt the persistent byte
    persist_loss = (supply.core_brownout && !deep)
                   || (supply.sleep_brownout && deep)
                   || supply.supply_cycled
                   || supply.por_event;
    if (persist_loss) begin
      s_nxt.persist = `DSWK_RST_PERSIST; // [R2]
    end

    // Any armed cause ends deep sleep; a fault needs no setup
    exit_cause = events.fault // [R19]
                 || events.watchdog
                 || events.alarm
                 || !events.reset_pin_n
                 || events.change_int;
    s_nxt.exit_req = (deep && exit_cause) || ulp_deep_wake; // [R18]
    s_nxt.wake_irq = ulp_sleep_wake; // [R12]

    // Post-wake reset clears watchdog control, its level flag and the outputs; wake flags and byte ride through
    if (!aresetn) begin
      s_nxt.wake_module_enable = 1'b0; // [R20]
      s_nxt.discharge_sink_enable = 1'b0;
      s_nxt.wake_level_flag = 1'b0;
      s_nxt.wake_irq = 1'b0;
      s_nxt.exit_req = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign wake_irq = s_r.wake_irq;
  assign deep_sleep_exit_req = s_r.exit_req;

endmodule : dswk_top

// ===== tb/dswk_monitor.sv
`timescale 1ns/100ps

module dswk_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // Power and wake
  input wire dswk_pkg::dswk_power_t power,
  input wire dswk_pkg::dswk_events_t events,
  input wire logic wake_capacitor_pin_low,
  input wire logic low_power_wake_output,
  input wire logic wake_irq,
  input wire logic deep_sleep_exit_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_rd_answer;
    ##[1:2] rvalid;
  endsequence
  sequence s_deep_cause;
    power.in_deep_sleep && (events.fault || events.watchdog || events.alarm ||
      !events.reset_pin_n || events.change_int);
  endsequence

  a_read_answer: assert property (s_rd_take |-> s_rd_answer)
    else $error("read not answered in time");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered in time");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_exit_cause: assert property (s_deep_cause |=> deep_sleep_exit_req)
    else $error("deep sleep cause gave no exit");
  a_exit_deep: assert property (deep_sleep_exit_req |->
    $past(power.in_deep_sleep) || $past(power.in_deep_sleep, 2))
    else $error("exit request outside deep sleep");
  a_irq_pulse: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt longer than one cycle");
  a_irq_sleep: assert property (wake_irq |->
    $past(power.in_sleep, 2) && !$past(power.in_deep_sleep, 2))
    else $error("wake interrupt outside ordinary sleep");
  a_irq_pin: assert property (wake_irq |-> $past(wake_capacitor_pin_low, 2))
    else $error("wake interrupt without low pin");
  a_out_pin: assert property (low_power_wake_output |-> $past(wake_capacitor_pin_low))
    else $error("wake output without low pin");
endmodule : dswk_monitor

bind dswk_top dswk_monitor u_monitor (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rdata(rdata), .power(power), .events(events),
  .wake_capacitor_pin_low(wake_capacitor_pin_low),
  .low_power_wake_output(low_power_wake_output), .wake_irq(wake_irq),
  .deep_sleep_exit_req(deep_sleep_exit_req));

// ===== tb/dswk_cap_model.sv
`timescale 1ns/100ps

module dswk_cap_model #(
  parameter int DISCH = 20
) (
  input wire logic aclk,
  input wire logic charge,
  input wire logic sink_on,
  output logic pin_low
);
  int level = 0;

  // Charged full by pin drive, bleeds only through the sink
  always @(posedge aclk) begin
    if (charge) begin
      level <= DISCH;
    end else if (sink_on && level > 0) begin
      level <= level - 1;
    end
  end
  assign pin_low = (level == 0);
endmodule : dswk_cap_model

// ===== tb/test_deep_sleep_wake_status.sv
`timescale 1ns/100ps
`include "dswk_defines.svh"

module test_deep_sleep_wake_status;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pin_low, sink_on, lpw_out, wake_irq, exit_req;
  logic charge = 0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  dswk_pkg::dswk_power_t power = 2'b00;
  dswk_pkg::dswk_supply_t supply = 5'b11000;
  dswk_pkg::dswk_events_t events = 5'b00010;
  int miscompares = 0, tests_run = 0, irq_cnt = 0, n;
  logic [4:0] evt [5] = '{5'b10010, 5'b01010, 5'b00110, 5'b00000, 5'b00011};
  logic [7:0] lo [5] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h00};
  logic [7:0] hi [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ERR = 2'h2;

  dswk_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .power(power), .supply(supply), .events(events),
    .wake_capacitor_pin_low(pin_low), .discharge_sink_on(sink_on),
    .low_power_wake_output(lpw_out), .wake_irq(wake_irq), .deep_sleep_exit_req(exit_req));
  dswk_cap_model #(.DISCH(20)) u_cap (.aclk(aclk), .charge(charge), .sink_on(sink_on),
    .pin_low(pin_low));

  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (wake_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task wr(input logic [13:0] i, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // Response ready stays high between transfers
    check("bresp", {6'h0, bresp}, {6'h0, er});
  endtask : wr

  task rd(input logic [13:0] i, input logic [7:0] exp, input logic [1:0] er);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check("rdata", rdata[7:0], exp);
    check("rresp", {6'h0, rresp}, {6'h0, er});
  endtask : rd

  task ev(input logic [4:0] v);
    events <= v;
    @(posedge aclk);
    events <= 5'b00010;
    @(posedge aclk);
  endtask : ev

  task sup(input logic [4:0] s);
    supply <= s;
    @(posedge aclk);
    supply <= 5'b01000;
    @(posedge aclk);
  endtask : sup

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #100000;
    miscompares++;
    final_report;
  end

  initial begin
    cyc(4);
    supply <= 5'b01000;
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    rd(`DSWK_IDX_WAKE_LOW, 8'h01, OK);
    rd(`DSWK_IDX_WAKE_HIGH, 8'h00, OK);
    rd(14'h0f4e, 8'h00, ERR);
    wr(14'h0f4e, 8'hff, ERR);
    $display("test reset values done");
    wr(`DSWK_IDX_WAKE_LOW, 8'hff, OK);
    wr(`DSWK_IDX_WAKE_HIGH, 8'hff, OK);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    rd(`DSWK_IDX_WAKE_LOW, 8'hbd, OK);
    rd(`DSWK_IDX_WAKE_HIGH, 8'h01, OK);
    $display("test reserved bits done");
    wr(`DSWK_IDX_PERSIST1, 8'ha5, OK);
    power <= 2'b11;
    wr(`DSWK_IDX_PERSIST1, 8'h5a, OK);
    sup(5'b01100);
    power <= 2'b00;
    sup(5'b01010);
    rd(`DSWK_IDX_PERSIST1, 8'ha5, OK);
    for (int k = 0; k < 3; k++) begin
      wr(`DSWK_IDX_PERSIST1, 8'ha5, OK);
      power <= (k == 1) ? 2'b11 : 2'b00;
      cyc(1);
      sup((k == 0) ? 5'b01100 : (k == 1) ? 5'b01010 : 5'b01001);
      power <= 2'b00;
      rd(`DSWK_IDX_PERSIST1, 8'h00, OK);
    end
    $display("test persistent byte done");
    for (int k = 0; k < 5; k++) begin
      wr(`DSWK_IDX_WAKE_LOW, 8'h00, OK);
      wr(`DSWK_IDX_WAKE_HIGH, 8'h00, OK);
      power <= 2'b11;
      cyc(1);
      ev(evt[k]);
      check("exit_req", {7'h0, exit_req}, 8'h01);
      power <= 2'b00;
      cyc(2);
      rd(`DSWK_IDX_WAKE_LOW, lo[k], OK);
      rd(`DSWK_IDX_WAKE_HIGH, hi[k], OK);
    end
    wr(`DSWK_IDX_WAKE_HIGH, 8'h00, OK);
    ev(5'b11101);
    check("exit_req", {7'h0, exit_req}, 8'h00);
    rd(`DSWK_IDX_WAKE_LOW, 8'h00, OK);
    rd(`DSWK_IDX_WAKE_HIGH, 8'h00, OK);
    sup(5'b10000);
    rd(`DSWK_IDX_WAKE_LOW, 8'h00, OK);
    sup(5'b11000);
    rd(`DSWK_IDX_WAKE_LOW, 8'h01, OK);
    $display("test wake flags done");
    // Software side: enable module and sink, then charge
    wr(`DSWK_IDX_WDT_CTL, 8'h03, OK);
    charge <= 1'b1;
    cyc(2);
    charge <= 1'b0;
    cyc(2);
    check("sink_on", {7'h0, sink_on}, 8'h01);
    check("wake_out", {7'h0, lpw_out}, 8'h00);
    power <= 2'b10;
    n = 0;
    while (wake_irq !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    cyc(3);
    check("irq_count", irq_cnt[7:0], 8'h01);
    check("wake_out", {7'h0, lpw_out}, 8'h01);
    power <= 2'b00;
    rd(`DSWK_IDX_WDT_CTL, 8'h23, OK);
    rd(`DSWK_IDX_WAKE_LOW, 8'h01, OK);
    $display("test sleep wake done");
    wr(`DSWK_IDX_WAKE_LOW, 8'h00, OK);
    wr(`DSWK_IDX_DS_CTL_HIGH, 8'h02, OK);
    wr(`DSWK_IDX_DS_CTL_LOW, 8'h00, OK);
    for (int k = 0; k < 2; k++) begin
      charge <= 1'b1;
      cyc(2);
      charge <= 1'b0;
      power <= 2'b11;
      n = 0;
      while (exit_req !== 1'b1 && n < 40) begin
        @(posedge aclk);
        n++;
      end
      check("exit_req", {7'h0, exit_req}, (k == 0) ? 8'h01 : 8'h00);
      power <= 2'b00;
      cyc(3);
      rd(`DSWK_IDX_WAKE_LOW, (k == 0) ? 8'h20 : 8'h00, OK);
      wr(`DSWK_IDX_WAKE_LOW, 8'h00, OK);
      wr(`DSWK_IDX_DS_CTL_LOW, 8'h04, OK);
    end
    check("irq_count", irq_cnt[7:0], 8'h01);
    $display("test deep sleep wake done");
    final_report;
  end
endmodule : test_deep_sleep_wake_status
